// ### hw/mbs_pkg.sv
// Functional notes
// - Sample on test clock rise, launch on fall
// - Mode select steers controller, sampled on rise
// - Mode select and data input pulled up
// - Only the selected register sits in path
// - Serial input enters selected register MSB
// - Serial output is LSB, changes on fall
// - Serial output driven only while shifting
// - Five high mode-select rises reset controller
// - Controller reset leaves memory operation alone
// - Power-up reset, serial output starts undriven
// - Follows the 2001 boundary-scan architecture
// - Test clock drives only test port logic
// - Three-bit instruction, identification after reset
// - Capture-instruction loads 01 into low bits
// - Bypass is one bit when selected
// - Identification captures 32-bit code, shifts out
package mbs_pkg;
   localparam int MBS_IR_W = 3;
   localparam int MBS_ID_W = 32;
   localparam int MBS_BSR_W = 109;
   localparam int MBS_SYNC_STAGES = 2;
   // Instruction codes
   localparam logic [2:0] MBS_IR_EXTEST = 3'h0;
   localparam logic [2:0] MBS_IR_IDCODE = 3'h1;
   localparam logic [2:0] MBS_IR_SAMPLEZ = 3'h2;
   localparam logic [2:0] MBS_IR_SAMPLE = 3'h4;
   localparam logic [2:0] MBS_IR_BYPASS = 3'h7;
   localparam logic [2:0] MBS_IR_RESET = MBS_IR_IDCODE;
   localparam logic [1:0] MBS_IR_CAPTURE = 2'h1;
   // Arbitrary identification value, not a real part code
   localparam logic [31:0] MBS_ID_DEFAULT = 32'h0000_0001;

   typedef enum logic [3:0] {
      MBS_RESET, MBS_IDLE, MBS_SEL_DR, MBS_CAP_DR, MBS_SH_DR, MBS_EX1_DR,
      MBS_PAU_DR, MBS_EX2_DR, MBS_UPD_DR, MBS_SEL_IR, MBS_CAP_IR,
      MBS_SH_IR, MBS_EX1_IR, MBS_PAU_IR, MBS_EX2_IR, MBS_UPD_IR
   } mbs_state_e;

   // Serial output pin group
   typedef struct packed {
      logic data;
      logic oe_n;
   } mbs_tdo_s;
endpackage

// ### hw/mbs_tap.sv
`timescale 1ns/100ps
module mbs_tap #(
   parameter logic [31:0] ID_CODE = mbs_pkg::MBS_ID_DEFAULT,
   parameter int BSR_W = mbs_pkg::MBS_BSR_W
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic [BSR_W-1:0] pin_snap,
   output mbs_pkg::mbs_tdo_s tdo_ff,
   output logic [BSR_W-1:0] bsr_upd_ff,
   output logic [2:0] ir_ff,
   output logic [3:0] state_ff
);
   import mbs_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers; pins from another clock domain
   logic [1:0] tck_s_ff, tms_s_ff, tdi_s_ff;
   logic tck_d_ff;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tck_s_ff <= 2'h0;
         tms_s_ff <= 2'h3; // Pulled up, idle high
         tdi_s_ff <= 2'h3;
         tck_d_ff <= 1'b0;
      end else begin
         tck_s_ff <= {tck_s_ff[0], tck};
         tms_s_ff <= {tms_s_ff[0], tms};
         tdi_s_ff <= {tdi_s_ff[0], tdi};
         tck_d_ff <= tck_s_ff[1];
      end
   end

   // Edges of the test clock; nothing advances while it is held low
   logic rise, fall;
   assign rise = tck_s_ff[1] & ~tck_d_ff;
   assign fall = ~tck_s_ff[1] & tck_d_ff;

   ////////////////////////////////////////////////////////////////////
   // Controller, sixteen states
   mbs_state_e st_ff, nxt_st;
   logic m;
   assign m = tms_s_ff[1];
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         MBS_RESET: nxt_st = m ? MBS_RESET : MBS_IDLE;
         MBS_IDLE: nxt_st = m ? MBS_SEL_DR : MBS_IDLE;
         MBS_SEL_DR: nxt_st = m ? MBS_SEL_IR : MBS_CAP_DR;
         MBS_CAP_DR: nxt_st = m ? MBS_EX1_DR : MBS_SH_DR;
         MBS_SH_DR: nxt_st = m ? MBS_EX1_DR : MBS_SH_DR;
         MBS_EX1_DR: nxt_st = m ? MBS_UPD_DR : MBS_PAU_DR;
         MBS_PAU_DR: nxt_st = m ? MBS_EX2_DR : MBS_PAU_DR;
         MBS_EX2_DR: nxt_st = m ? MBS_UPD_DR : MBS_SH_DR;
         MBS_UPD_DR: nxt_st = m ? MBS_SEL_DR : MBS_IDLE;
         MBS_SEL_IR: nxt_st = m ? MBS_RESET : MBS_CAP_IR; // 5 highs
         MBS_CAP_IR: nxt_st = m ? MBS_EX1_IR : MBS_SH_IR;
         MBS_SH_IR: nxt_st = m ? MBS_EX1_IR : MBS_SH_IR;
         MBS_EX1_IR: nxt_st = m ? MBS_UPD_IR : MBS_PAU_IR;
         MBS_PAU_IR: nxt_st = m ? MBS_EX2_IR : MBS_PAU_IR;
         MBS_EX2_IR: nxt_st = m ? MBS_UPD_IR : MBS_SH_IR;
         MBS_UPD_IR: nxt_st = m ? MBS_SEL_DR : MBS_IDLE;
         default: nxt_st = MBS_RESET;
      endcase
   end

   // Power-up reset lands in test-logic-reset; memory path untouched
   always_ff @(posedge clk) begin
      if (!rstn) st_ff <= MBS_RESET;
      else if (rise) st_ff <= nxt_st;
   end
   assign state_ff = st_ff;

   ////////////////////////////////////////////////////////////////////
   // Instruction shift and hold registers
   logic [2:0] ir_sh_ff;
   always_ff @(posedge clk) begin
      if (!rstn || st_ff == MBS_RESET) begin
         ir_sh_ff <= MBS_IR_RESET;
         ir_ff <= MBS_IR_RESET;
      end else if (rise) begin
         case (st_ff)
            MBS_CAP_IR: ir_sh_ff <= {1'b0, MBS_IR_CAPTURE};
            MBS_SH_IR: ir_sh_ff <= {tdi_s_ff[1], ir_sh_ff[2:1]};
            MBS_UPD_IR: ir_ff <= ir_sh_ff;
            default: ir_sh_ff <= ir_sh_ff;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data registers: bypass, identification, boundary
   logic byp_ff;
   logic [31:0] id_ff;
   logic [BSR_W-1:0] bsr_ff;
   logic sel_byp, sel_id;
   assign sel_id = (ir_ff == MBS_IR_IDCODE);
   assign sel_byp = (ir_ff == MBS_IR_BYPASS) || (ir_ff == 3'h3) ||
                    (ir_ff == 3'h5) || (ir_ff == 3'h6);
   always_ff @(posedge clk) begin
      if (!rstn) begin
         byp_ff <= 1'b0;
         id_ff <= '0;
         bsr_ff <= '0;
      end else if (rise && st_ff == MBS_CAP_DR) begin
         byp_ff <= 1'b0;
         id_ff <= ID_CODE;
         bsr_ff <= pin_snap;
      end else if (rise && st_ff == MBS_SH_DR) begin
         if (sel_byp) byp_ff <= tdi_s_ff[1];
         else if (sel_id) id_ff <= {tdi_s_ff[1], id_ff[31:1]};
         else bsr_ff <= {tdi_s_ff[1], bsr_ff[BSR_W-1:1]};
      end
   end

   // Update latch; output-enable cell preset high at reset
   always_ff @(posedge clk) begin
      if (!rstn || st_ff == MBS_RESET) begin
         bsr_upd_ff <= '0;
         bsr_upd_ff[BSR_W-1] <= 1'b1;
      end else if (rise && st_ff == MBS_UPD_DR && !sel_byp && !sel_id) begin
         bsr_upd_ff <= bsr_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Serial output launched on the falling edge
   logic so_bit, shifting;
   assign shifting = (st_ff == MBS_SH_DR) || (st_ff == MBS_SH_IR);
   always_comb begin
      if (st_ff == MBS_SH_IR) so_bit = ir_sh_ff[0];
      else if (sel_byp) so_bit = byp_ff;
      else if (sel_id) so_bit = id_ff[0];
      else so_bit = bsr_ff[0];
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tdo_ff.data <= 1'b0;
         tdo_ff.oe_n <= 1'b1; // Undriven from power-up
      end else if (fall) begin
         tdo_ff.data <= so_bit;
         tdo_ff.oe_n <= ~shifting;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Check helper: run of high mode-select rises, saturates at five
   logic [2:0] hi_run_ff;
   always_ff @(posedge clk) begin
      if (!rstn) hi_run_ff <= 3'h0;
      else if (rise && !m) hi_run_ff <= 3'h0;
      else if (rise && hi_run_ff != 3'h5) hi_run_ff <= hi_run_ff + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks on the serial output pin
   a_tdo_falls: assert property (
      @(posedge clk) disable iff (!rstn)
      $changed(tdo_ff) |-> $past(fall))
      else $error("serial output moved off a falling edge");
   a_tdo_off_idle: assert property (
      @(posedge clk) disable iff (!rstn)
      (fall && !shifting) |=> tdo_ff.oe_n)
      else $error("serial output driven outside shift");
   a_tdo_on_shift: assert property (
      @(posedge clk) disable iff (!rstn)
      (fall && shifting) |=> !tdo_ff.oe_n)
      else $error("serial output not driven while shifting");
   a_tdo_lsb_ir: assert property (
      @(posedge clk) disable iff (!rstn)
      (fall && st_ff == MBS_SH_IR) |=> tdo_ff.data == $past(ir_sh_ff[0]))
      else $error("instruction LSB not on serial output");
   a_tdo_lsb_id: assert property (
      @(posedge clk) disable iff (!rstn)
      (fall && st_ff == MBS_SH_DR && sel_id) |=>
         tdo_ff.data == $past(id_ff[0]))
      else $error("identification LSB not on serial output");
   // Undriven whenever the controller sits in reset
   a_tdo_off_reset: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_ff == MBS_RESET) |-> tdo_ff.oe_n)
      else $error("serial output driven in reset state");

   ////////////////////////////////////////////////////////////////////
   // Checks on the controller
   a_state_rise: assert property (
      @(posedge clk) disable iff (!rstn)
      $changed(st_ff) |-> $past(rise))
      else $error("controller moved without a rising edge");
   // A stopped test clock must freeze the controller
   a_clock_low: assert property (
      @(posedge clk) disable iff (!rstn)
      (!tck_s_ff[1] && !tck_d_ff) |=> $stable(st_ff))
      else $error("controller moved with test clock low");
   a_leave_reset: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && !m && st_ff == MBS_RESET) |=> st_ff == MBS_IDLE)
      else $error("low mode select did not leave reset");
   a_tms_reset: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && m && st_ff == MBS_SEL_IR) |=> st_ff == MBS_RESET)
      else $error("held mode select did not reset");
   // Five highs from any state, counted independently of the table
   a_five_high: assert property (
      @(posedge clk) disable iff (!rstn)
      (hi_run_ff == 3'h5) |-> st_ff == MBS_RESET)
      else $error("five high mode-select rises did not reset");

   ////////////////////////////////////////////////////////////////////
   // Checks on the instruction path
   a_ir_reset: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_ff == MBS_RESET) |=> ir_ff == MBS_IR_IDCODE)
      else $error("instruction not identification after reset");
   a_ir_capture: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_CAP_IR) |=> ir_sh_ff[1:0] == 2'h1)
      else $error("capture-instruction pattern wrong");
   a_ir_msb_in: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_SH_IR) |=> ir_sh_ff[2] == $past(tdi_s_ff[1]))
      else $error("instruction shift did not enter at MSB");
   a_ir_update: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_UPD_IR) |=> ir_ff == $past(ir_sh_ff))
      else $error("instruction not updated");
   // Instruction only moves in update or reset
   a_ir_steady: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_ff != MBS_UPD_IR && st_ff != MBS_RESET) |=> $stable(ir_ff))
      else $error("instruction changed outside update");
   a_ir_sh_rise: assert property (
      @(posedge clk) disable iff (!rstn)
      $changed(ir_sh_ff) |-> $past(rise) || $past(st_ff) == MBS_RESET)
      else $error("instruction shifter moved off a rising edge");

   ////////////////////////////////////////////////////////////////////
   // Checks on the data registers
   a_id_capture: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_CAP_DR) |=> id_ff == ID_CODE)
      else $error("identification code not captured");
   a_id_msb_in: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_SH_DR && sel_id) |=>
         id_ff[31] == $past(tdi_s_ff[1]))
      else $error("identification shift did not enter at MSB");
   a_bsr_msb_in: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_SH_DR && !sel_id && !sel_byp) |=>
         bsr_ff[BSR_W-1] == $past(tdi_s_ff[1]))
      else $error("boundary shift did not enter at MSB");
   a_byp_capture: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_CAP_DR) |=> !byp_ff)
      else $error("bypass bit not cleared on capture");
   a_byp_shift: assert property (
      @(posedge clk) disable iff (!rstn)
      (rise && st_ff == MBS_SH_DR && sel_byp) |=>
         byp_ff == $past(tdi_s_ff[1]))
      else $error("bypass bit did not take serial input");
   // Output-enable cell of the update latch preset in reset
   a_upd_preset: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_ff == MBS_RESET) |=> bsr_upd_ff[BSR_W-1])
      else $error("update latch enable cell not preset");
endmodule

// ### dv/mbs_ctl_model.sv
`timescale 1ns/100ps
// Board-side scan controller; test clock rests low between bits
module mbs_ctl_model (
   input wire logic clk,
   input wire logic tdo,
   output logic tck,
   output logic tms,
   output logic tdi
);
   // Idle levels match the pull-ups and a stopped clock
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One bit: set up while low, sample output, then rise
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      repeat (10) @(posedge clk);
      #1 q = tdo;
      tck = 1'b1;
      repeat (10) @(posedge clk);
      #1 tck = 1'b0;
   endtask
endmodule

// ### dv/memory_boundary_scan_tap_test.sv
`timescale 1ns/100ps
module memory_boundary_scan_tap_test;
   import mbs_pkg::*;
   // Arbitrary identification value
   localparam logic [31:0] ID = 32'h5A3C_96E1;
   logic clk, rstn, tck, tms, tdi, tdo_w;
   mbs_tdo_s tdo;
   logic [2:0] ir;
   logic [3:0] st;
   logic [31:0] d;
   logic [MBS_BSR_W-1:0] upd;
   int n_fail = 0;
   int check_count = 0;
   // Released serial output shows the inverse, so a stray read mismatches
   assign tdo_w = tdo.oe_n ? ~tdo.data : tdo.data;
   mbs_tap #(.ID_CODE(ID)) dut (.clk(clk), .rstn(rstn), .tck(tck),
      .tms(tms), .tdi(tdi), .pin_snap('0), .tdo_ff(tdo),
      .bsr_upd_ff(upd), .ir_ff(ir), .state_ff(st));
   mbs_ctl_model u_ctl (.clk(clk), .tdo(tdo_w), .tck(tck), .tms(tms),
      .tdi(tdi));
   ////////////////////////////////////////////////////////////////////////
   // System clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Walk the controller with a mode-select pattern, LSB first
   task automatic go(input logic [7:0] m, input int n);
      logic q;
      for (int i = 0; i < n; i++) u_ctl.step(m[i], 1'b1, q);
   endtask
   // Shift n bits, leave on the last, then update and idle
   task automatic shift(input int n, input logic [31:0] din,
      output logic [31:0] dout);
      logic q;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         u_ctl.step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      go(8'h01, 2);
   endtask
   task automatic load_ir(input logic [2:0] code);
      go(8'h03, 4);
      shift(3, {29'h0, code}, d);
      chk(d[2:0], MBS_IR_CAPTURE);
      chk(ir, code);
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_powerup;
      chk(st, MBS_RESET);
      chk(ir, MBS_IR_RESET);
      chk(tdo.oe_n, 1'b1);
      chk(upd[MBS_BSR_W-1], 1'b1);
      chk(upd[31:0], 32'h0000_0000);
   endtask
   task automatic t_instr;
      go(8'h00, 1);
      load_ir(MBS_IR_SAMPLE);
      chk(st, MBS_IDLE);
      chk(tdo.oe_n, 1'b1);
   endtask
   task automatic t_idcode;
      go(8'h1F, 5);
      go(8'h02, 4); // Reset, idle, select, capture, into shift
      shift(32, '0, d);
      chk(d, ID);
   endtask
   // Reserved codes must fall back to the one-bit path
   task automatic t_bypass;
      logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, MBS_IR_BYPASS};
      foreach (codes[k]) begin
         load_ir(codes[k]);
         go(8'h01, 3);
         shift(8, 32'hA5, d);
         chk(d[7:0], 8'h4A);
      end
   endtask
   // Reset from mid-shift, then a stopped test clock keeps the controller in idle
   task automatic t_tms_reset;
      go(8'h01, 3);
      go(8'h1F, 5);
      chk(st, MBS_RESET);
      chk(ir, MBS_IR_RESET);
      go(8'h00, 1);
      repeat (40) @(posedge clk);
      chk(st, MBS_IDLE);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rstn = 1'b0;
      repeat (4) @(posedge clk);
      #1 rstn = 1'b1;
      t_powerup;
      t_instr;
      t_idcode;
      t_bypass;
      t_tms_reset;
      stop_test;
   end
   // About 150 bits at 160 ns need 24 us; allow several times that
   initial begin
      #200000;
      n_fail++;
      stop_test;
   end
endmodule
